// ===== mmpp_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmpp_cpu_model
  import mmpp_pkg::*;
(
  input wire logic clk,
  output var mmpp_req_t busReq
);
  initial busReq = '0;
  // Word access, one strobe edge, then idle with inverted lines
  task automatic acc(input logic rd, input logic [31:0] a, d, input int gap);
    @(posedge clk);
    busReq <= '{rd, !rd, a, d};
    @(posedge clk);
    busReq <= '{1'b0, 1'b0, ~a, ~d};
    repeat (gap) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== mmpp_digit_store.sv
`timescale 1ns/1ns
`default_nettype none

module mmpp_digit_store
  import mmpp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wrEn,
  input  wire logic             wrSel,
  input  wire logic [31:0]      wrData,
  output var  logic [31:0]      lowWord,
  output var  logic [31:0]      highWord
);

  logic [31:0] low_q;
  logic [31:0] low_d;
  logic [31:0] high_q;
  logic [31:0] high_d;

  // ----------------------------------------
  // Two digit words
  // ----------------------------------------
  always_comb begin
    low_d  = low_q;
    high_d = high_q;
    if (wrEn && !wrSel) begin
      low_d = wrData;
    end
    if (wrEn && wrSel) begin
      high_d = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_q  <= ResetWord;
      high_q <= ResetWord;
    end else begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end

  assign lowWord  = low_q;
  assign highWord = high_q;

endmodule

`default_nettype wire

// ===== mmpp_parallel_ports.sv
// Behaviour
// - Each port has a base and up to four 32-bit word registers.
// - Output ports have writable data, input ports readable data.
// - A bidirectional port adds a direction register of data width.
// - Direction bit 0 makes a data bit input, 1 makes it output.
// - Red lamp port: 18-bit write-only register at FF200000.
// - Green lamp port: nine-bit output register at FF200010.
// - Word writes to lamps; bits above the width are dropped.
// - Digit words at FF200020 (digits 3..0) and FF200030 (7..4).
// - Stored digit bits drive segments directly, no decoding.
// - Slide switch port: 18-bit read-only register at FF200040.
// - Push-button port: three 4-bit word registers from FF200050.
// - Remaining push-button registers decode at FF200058 and FF20005C.
`timescale 1ns/1ns
`default_nettype none

module mmpp_parallel_ports
  import mmpp_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire mmpp_req_t                 busReq,
  output var  mmpp_rsp_t                 busRsp,
  output var  logic [RedWidth-1:0]       redLamps,
  output var  logic [GreenWidth-1:0]     greenLamps,
  output var  logic [SegWidth-1:0]       digitLow [DigitCount],
  output var  logic [SegWidth-1:0]       digitHigh [DigitCount],
  input  wire logic [SwWidth-1:0]        slideSwitches,
  input  wire logic [KeyWidth-1:0]       pushButtons
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // No port here is bidirectional, so base plus four stays unmapped
  logic hitRed;
  logic hitGreen;
  logic hitDigLow;
  logic hitDigHigh;
  logic hitSw;
  logic hitKey;
  logic hitKeyA;
  logic hitKeyB;

  always_comb begin
    hitRed     = (busReq.addr == AddrRedLamp);
    hitGreen   = (busReq.addr == AddrGreenLamp);
    hitDigLow  = (busReq.addr == AddrDigitLow);
    hitDigHigh = (busReq.addr == AddrDigitHigh);
    hitSw      = (busReq.addr == AddrSlideSw);
    hitKey     = (busReq.addr == AddrKeyData);
    hitKeyA    = (busReq.addr == AddrKeyExtraA);
    hitKeyB    = (busReq.addr == AddrKeyExtraB);
  end

  // ----------------------------------------
  // Lamp and push-button registers
  // ----------------------------------------
  logic [RedWidth-1:0]   red_q;
  logic [RedWidth-1:0]   red_d;
  logic [GreenWidth-1:0] green_q;
  logic [GreenWidth-1:0] green_d;
  logic [KeyWidth-1:0]   keyA_q;
  logic [KeyWidth-1:0]   keyA_d;
  logic [KeyWidth-1:0]   keyB_q;
  logic [KeyWidth-1:0]   keyB_d;

  always_comb begin
    red_d   = red_q;
    green_d = green_q;
    keyA_d  = keyA_q;
    keyB_d  = keyB_q;
    if (busReq.write && hitRed) begin
      red_d = busReq.wdata[RedWidth-1:0];
    end
    if (busReq.write && hitGreen) begin
      green_d = busReq.wdata[GreenWidth-1:0];
    end
    if (busReq.write && hitKeyA) begin
      keyA_d = busReq.wdata[KeyWidth-1:0];
    end
    if (busReq.write && hitKeyB) begin
      keyB_d = busReq.wdata[KeyWidth-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      red_q   <= ResetWord[RedWidth-1:0];
      green_q <= ResetWord[GreenWidth-1:0];
      keyA_q  <= ResetWord[KeyWidth-1:0];
      keyB_q  <= ResetWord[KeyWidth-1:0];
    end else begin
      red_q   <= red_d;
      green_q <= green_d;
      keyA_q  <= keyA_d;
      keyB_q  <= keyB_d;
    end
  end

  assign redLamps   = red_q;
  assign greenLamps = green_q;

  // ----------------------------------------
  // Digit words
  // ----------------------------------------
  logic [31:0] lowWord;
  logic [31:0] highWord;

  mmpp_digit_store uDigits (
    .clk      (clk),
    .nrst     (nrst),
    .wrEn     (busReq.write && (hitDigLow || hitDigHigh)),
    .wrSel    (hitDigHigh),
    .wrData   (busReq.wdata),
    .lowWord  (lowWord),
    .highWord (highWord)
  );

  for (genvar g = 0; g < DigitCount; g++) begin : gDigit
    assign digitLow[g]  = lowWord[g*LaneWidth +: SegWidth];
    assign digitHigh[g] = highWord[g*LaneWidth +: SegWidth];
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  mmpp_rsp_t rsp_q;
  mmpp_rsp_t rsp_d;

  always_comb begin
    rsp_d.valid = busReq.read;
    rsp_d.rdata = ResetWord;
    if (busReq.read) begin
      if (hitSw) begin
        rsp_d.rdata[SwWidth-1:0] = slideSwitches;
      end else if (hitKey) begin
        rsp_d.rdata[KeyWidth-1:0] = pushButtons;
      end else if (hitKeyA) begin
        rsp_d.rdata[KeyWidth-1:0] = keyA_q;
      end else if (hitKeyB) begin
        rsp_d.rdata[KeyWidth-1:0] = keyB_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign busRsp = rsp_q;

endmodule

`default_nettype wire

// ===== mmpp_parallel_ports_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mmpp_parallel_ports_tb
  import mmpp_pkg::*;
;
  logic                  clk = 0;
  logic                  nrst = 0;
  logic [SwWidth-1:0]    sw = '0;
  logic [KeyWidth-1:0]   keys = '0;
  logic [31:0]           rnd = 32'hE9A7;
  logic [31:0]           v;
  logic [31:0]           expQ [$];
  int                    mismatches = 0;
  int                    n_tests = 0;
  mmpp_req_t             busReq;
  mmpp_rsp_t             busRsp;
  logic [RedWidth-1:0]   red;
  logic [GreenWidth-1:0] grn;
  logic [SegWidth-1:0]   lo [DigitCount];
  logic [SegWidth-1:0]   hi [DigitCount];
  initial forever #5 clk = ~clk;
  mmpp_cpu_model cpu_u (.clk(clk), .busReq(busReq));
  mmpp_parallel_ports dut_u (.clk(clk), .nrst(nrst), .busReq(busReq), .busRsp(busRsp),
    .redLamps(red), .greenLamps(grn), .digitLow(lo), .digitHigh(hi),
    .slideSwitches(sw), .pushButtons(keys));
  function automatic logic [31:0] nxt();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expQ.push_back(e);
    cpu_u.acc(1'b1, a, 32'h0, int'(nxt() % 3));
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    cpu_u.acc(1'b0, a, d, 0);
    @(negedge clk);
  endtask
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Read answers are matched in issue order
  always @(posedge clk) if (busRsp.valid === 1'b1) begin
    if (expQ.size() > 0) chk(busRsp.rdata, expQ.pop_front());
    else chk(32'h1, 32'h0);
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(32'(red), 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = nxt();
      wr(AddrRedLamp, v);
      chk(32'(red), {14'h0, v[17:0]});
      wr(AddrGreenLamp, ~v);
      chk(32'(grn), {23'h0, ~v[8:0]});
      wr(AddrDigitLow, v);
      chk(32'({lo[3], lo[2]}), 32'({v[30:24], v[22:16]}));
      chk(32'({lo[1], lo[0]}), 32'({v[14:8], v[6:0]}));
      wr(AddrDigitHigh, ~v);
      chk(32'({hi[3], hi[2]}), 32'({~v[30:24], ~v[22:16]}));
      chk(32'({hi[1], hi[0]}), 32'({~v[14:8], ~v[6:0]}));
      @(posedge clk);
      sw <= v[31:14];
      keys <= v[3:0];
      rd(AddrSlideSw, {14'h0, v[31:14]});
      rd(AddrKeyData, {28'h0, v[3:0]});
      rd(AddrRedLamp, 32'h0);
      wr(AddrSlideSw, 32'h0);
      rd(AddrSlideSw, {14'h0, v[31:14]});
      wr(i[0] ? AddrKeyExtraB : AddrKeyExtraA, v);
      rd(i[0] ? AddrKeyExtraB : AddrKeyExtraA, {28'h0, v[3:0]});
      wr(32'hFF20_0004, 32'hFFFF_FFFF);
      rd(32'hFF20_0004, 32'h0);
      chk(32'(red), {14'h0, v[17:0]});
      $display("Round %0d done", i);
    end
    for (int i = 0; i < 20 && expQ.size() > 0; i++) @(posedge clk);
    wr(AddrRedLamp, 32'hFFFF_FFFF);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(32'({red, grn}), 32'h0);
    chk(32'({lo[0], hi[0]}), 32'h0);
    rd(AddrSlideSw, {14'h0, sw});
    $display("Reset test done");
    for (int i = 0; i < 20 && expQ.size() > 0; i++) @(posedge clk);
    if (expQ.size() > 0) chk(32'h0, 32'h1);
    stop_test();
  end
endmodule
bind mmpp_parallel_ports mmpp_props props_u (.clk(clk), .nrst(nrst), .busReq(busReq),
  .busRsp(busRsp), .redLamps(redLamps), .digitLow(digitLow), .digitHigh(digitHigh),
  .slideSwitches(slideSwitches));
`default_nettype wire

// ===== mmpp_pkg.sv
package mmpp_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned AddrWidth  = 32;
  localparam int unsigned DataWidth  = 32;
  localparam int unsigned RedWidth   = 18;
  localparam int unsigned GreenWidth = 9;
  localparam int unsigned SwWidth    = 18;
  localparam int unsigned KeyWidth   = 4;
  localparam int unsigned SegWidth   = 7;
  localparam int unsigned DigitCount = 4;
  localparam int unsigned LaneWidth  = 8;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [31:0] AddrRedLamp    = 32'hFF20_0000;
  localparam logic [31:0] AddrGreenLamp  = 32'hFF20_0010;
  localparam logic [31:0] AddrDigitLow   = 32'hFF20_0020;
  localparam logic [31:0] AddrDigitHigh  = 32'hFF20_0030;
  localparam logic [31:0] AddrSlideSw    = 32'hFF20_0040;
  localparam logic [31:0] AddrKeyData    = 32'hFF20_0050;
  localparam logic [31:0] AddrKeyExtraA  = 32'hFF20_0058;
  localparam logic [31:0] AddrKeyExtraB  = 32'hFF20_005C;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] ResetWord = 32'h0000_0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mmpp_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } mmpp_rsp_t;

endpackage

// ===== mmpp_props.sv
`timescale 1ns/1ns
`default_nettype none
module mmpp_props
  import mmpp_pkg::*;
(
  input wire logic                clk,
  input wire logic                nrst,
  input wire mmpp_req_t           busReq,
  input wire mmpp_rsp_t           busRsp,
  input wire logic [RedWidth-1:0] redLamps,
  input wire logic [SegWidth-1:0] digitLow [DigitCount],
  input wire logic [SegWidth-1:0] digitHigh [DigitCount],
  input wire logic [SwWidth-1:0]  slideSwitches
);
  logic [31:0] wdQ;
  logic [31:0] ad;
  logic [17:0] swQ;
  logic        w;
  logic        r;
  assign ad = busReq.addr;
  assign w = busReq.write;
  assign r = busReq.read;
  always_ff @(posedge clk) begin
    wdQ <= busReq.wdata;
    swQ <= slideSwitches;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_red_write: assert property (w && ad == AddrRedLamp |=> redLamps == wdQ[17:0])
    else $error("red lamps wrong");
  a_red_hold: assert property (!(w && ad == AddrRedLamp) |=> $stable(redLamps))
    else $error("red lamps moved");
  a_digit_low: assert property (w && ad == AddrDigitLow |=> digitLow[3] == wdQ[30:24])
    else $error("low digits wrong");
  a_digit_high: assert property (w && ad == AddrDigitHigh |=> digitHigh[0] == wdQ[6:0])
    else $error("high digits wrong");
  a_switch_read: assert property (r && ad == AddrSlideSw |=> busRsp.rdata == {14'h0, swQ})
    else $error("switch read wrong");
  a_wo_read: assert property (r && ad == AddrRedLamp |=> busRsp.valid && busRsp.rdata == 0)
    else $error("write-only read not zero");
  a_no_valid: assert property (!r |=> !busRsp.valid)
    else $error("answer without read");
  a_read_valid: assert property (r |=> busRsp.valid)
    else $error("read not answered");
endmodule
`default_nettype wire
